// >>> fbe_pkg.sv
// Package for the memory bit error reporting block
package fbe_pkg;
    // Cause codes for the reset and NMI vectors (arbitrary values)
    localparam logic [7:0] RST_NONE = 8'h00;
    localparam logic [7:0] RST_UNCORR = 8'h1e;
    localparam logic [7:0] NMI_NONE = 8'h00;
    localparam logic [7:0] NMI_UNCORR = 8'h02;
    localparam logic [7:0] NMI_CORR = 8'h04;
    // Reset values of the controls
    localparam logic CTL_EN_RESET = 1'b0;
    localparam logic PWR_EN_RESET = 1'b1;
    // Length of the generated reset pulse in cycles
    localparam int PUC_CYCLES = 4;
    localparam logic [2:0] PUC_LAST = 3'h3;

    typedef struct packed {
        logic uncorrectable_reset_enable;
        logic uncorrectable_irq_enable;
        logic correctable_irq_enable;
        logic memory_power_enable;
    } fbe_ctl_a_t;

    typedef struct packed {
        logic uncorrectable_error_flag;
        logic correctable_error_flag;
    } fbe_flags_t;
endpackage : fbe_pkg

// >>> fbe_report.sv
// Bit error flagging, reset and NMI request logic of the memory controller
`timescale 1ns/1ps
// What this block does
// - An uncorrectable error sets the uncorrectable flag.
// - Uncorrectable flag with irq enable and reset disabled should request an NMI (silicon did not).
// - With the reset enable set, an uncorrectable error triggers a power-up-clear reset.
// - Such a reset loads the uncorrectable cause into the reset vector.
// - With its irq enable set, an uncorrectable error raises an NMI with its vector value.
// - With its irq enable set, a correctable error raises an NMI with its vector value unless an uncorrectable NMI arrives in the same cycle.
// - Spurious uncorrectable detection can occur at fast clock rates.
// - A reset from spurious detection leaves the vector at 0x00 and the flag at 0.
// - After low-power wake-up, false errors may be reported and acted on per the enables.
// - Writing the power enable to 0 switches the memory supply off.
module fbe_report (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ctl_we,
    input wire fbe_pkg::fbe_ctl_a_t ctl_wdata,
    input wire logic flag_clr_we,
    input wire fbe_pkg::fbe_flags_t flag_clr_mask,
    input wire logic uncorr_detect,
    input wire logic corr_detect,
    input wire logic spurious_detect,
    input wire logic nmi_ack,
    output fbe_pkg::fbe_ctl_a_t ctl,
    output fbe_pkg::fbe_flags_t flags,
    output logic [7:0] reset_cause_vector,
    output logic [7:0] system_nmi_vector,
    output logic nmi_req,
    output logic power_up_clear_reset,
    output logic memory_power_enable
);
    import fbe_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // One-hot states of the reset pulse generator
    typedef enum logic [1:0] {
        PUC_IDLE = 2'b01,
        PUC_PULSE = 2'b10
    } fbe_puc_state_t;

    fbe_puc_state_t puc_state;
    fbe_puc_state_t next_puc_state;
    logic [2:0] puc_cnt;
    logic [2:0] next_puc_cnt;
    fbe_ctl_a_t next_ctl;
    logic next_power;
    logic [7:0] next_cause;
    logic next_nmi_req;

    // Set beats a clear arriving in the same cycle
    function automatic logic flag_next(
        input logic set,
        input logic held,
        input logic clr_we,
        input logic clr_bit
    );
        return set | (held & ~(clr_we & clr_bit));
    endfunction : flag_next

    ////////////////////////////////////////////////////////////////////
    wire puc_busy = (puc_state == PUC_PULSE);
    wire puc_done = puc_busy & (puc_cnt == PUC_LAST);
    // Spurious detection and genuine errors both act; only genuine ones record
    wire uncorr_any = uncorr_detect | spurious_detect;
    wire trig_puc = uncorr_any & ctl.uncorrectable_reset_enable & ~puc_busy;
    wire uncorr_nmi = uncorr_detect & ctl.uncorrectable_irq_enable;
    wire corr_nmi = corr_detect & ctl.correctable_irq_enable;
    wire next_uflag = flag_next(uncorr_detect, flags.uncorrectable_error_flag,
        flag_clr_we, flag_clr_mask.uncorrectable_error_flag);
    wire next_cflag = flag_next(corr_detect, flags.correctable_error_flag,
        flag_clr_we, flag_clr_mask.correctable_error_flag);
    // Uncorrectable outranks correctable; a fresh cause outranks the ack
    wire [7:0] next_nmi_vec = uncorr_nmi ? NMI_UNCORR
        : corr_nmi ? NMI_CORR
        : nmi_ack ? NMI_NONE : system_nmi_vector;
    assign next_nmi_req = uncorr_nmi | corr_nmi | (nmi_req & ~nmi_ack);
    assign next_ctl = ctl_we ? ctl_wdata : ctl;
    assign next_power = ctl_we ? ctl_wdata.memory_power_enable : memory_power_enable;
    // Spurious-only reset leaves the cause undefined, so it reads as none
    assign next_cause = uncorr_detect ? RST_UNCORR : RST_NONE;
    assign next_puc_cnt = (puc_busy && !puc_done) ? puc_cnt + 3'h1 : 3'h0;

    // Detections during the pulse are ignored, so the pulse never stretches
    always_comb begin
        next_puc_state = puc_state;
        unique case (puc_state)
            PUC_IDLE: begin
                if (trig_puc) next_puc_state = PUC_PULSE;
            end
            PUC_PULSE: begin
                if (puc_done) next_puc_state = PUC_IDLE;
            end
            default: begin
                next_puc_state = PUC_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Brown-out reset only; the generated reset must not clear its own record
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctl <= '{CTL_EN_RESET, CTL_EN_RESET, CTL_EN_RESET, PWR_EN_RESET};
            memory_power_enable <= PWR_EN_RESET;
        end else begin
            ctl <= next_ctl;
            memory_power_enable <= next_power;
        end
    end

    // Flags survive the generated reset so software can poll them afterwards
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= '{next_uflag, next_cflag};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            system_nmi_vector <= NMI_NONE;
            nmi_req <= 1'b0;
        end else begin
            system_nmi_vector <= next_nmi_vec;
            nmi_req <= next_nmi_req;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            puc_state <= PUC_IDLE;
            puc_cnt <= '0;
            power_up_clear_reset <= 1'b0;
        end else begin
            puc_state <= next_puc_state;
            puc_cnt <= next_puc_cnt;
            power_up_clear_reset <= (next_puc_state == PUC_PULSE);
        end
    end

    // Loaded only when a reset is launched, so it reads back after the pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reset_cause_vector <= RST_NONE;
        end else if (trig_puc) begin
            reset_cause_vector <= next_cause;
        end
    end

    ////////////////////////////////////////////////////////////////////
    chk_puc_on_error: assert property (@(posedge mclk) disable iff (rst)
        trig_puc |=> power_up_clear_reset [*4] ##1 !power_up_clear_reset)
        else $error("reset pulse length wrong");
    chk_cause_loaded: assert property (@(posedge mclk) disable iff (rst)
        (trig_puc && uncorr_detect) |=> reset_cause_vector == RST_UNCORR)
        else $error("reset cause not loaded");
    chk_spurious_silent: assert property (@(posedge mclk) disable iff (rst)
        (trig_puc && !uncorr_detect) |=> reset_cause_vector == RST_NONE)
        else $error("spurious reset recorded");
    chk_uflag_set: assert property (@(posedge mclk) disable iff (rst)
        uncorr_detect |=> flags.uncorrectable_error_flag)
        else $error("uncorrectable flag not set");
    chk_flag_hold: assert property (@(posedge mclk) disable iff (rst)
        (flags.correctable_error_flag && !flag_clr_we) |=> flags.correctable_error_flag)
        else $error("flag lost without clear");
    chk_unmi_vec: assert property (@(posedge mclk) disable iff (rst)
        (uncorr_detect && ctl.uncorrectable_irq_enable)
        |=> nmi_req && system_nmi_vector == NMI_UNCORR)
        else $error("uncorrectable NMI missing");
    chk_cnmi_vec: assert property (@(posedge mclk) disable iff (rst)
        (corr_detect && ctl.correctable_irq_enable && !uncorr_detect)
        |=> nmi_req && system_nmi_vector == NMI_CORR)
        else $error("correctable NMI missing");
    chk_no_nmi: assert property (@(posedge mclk) disable iff (rst)
        (!nmi_req && !uncorr_nmi && !corr_nmi) |=> !nmi_req)
        else $error("NMI without cause");
    chk_power_off: assert property (@(posedge mclk) disable iff (rst)
        (ctl_we && !ctl_wdata.memory_power_enable) |=> !memory_power_enable)
        else $error("memory power not switched off");

    // Pulse generator guards
    chk_puc_no_retrigger: assert property (@(posedge mclk) disable iff (rst)
        $rose(power_up_clear_reset) |=> power_up_clear_reset [*3] ##1 !power_up_clear_reset)
        else $error("reset pulse retriggered");
    chk_puc_needs_enable: assert property (@(posedge mclk) disable iff (rst)
        (!ctl.uncorrectable_reset_enable && !power_up_clear_reset) |=> !power_up_clear_reset)
        else $error("reset pulse without enable");
    chk_cause_stable: assert property (@(posedge mclk) disable iff (rst)
        !trig_puc |=> $stable(reset_cause_vector))
        else $error("reset cause changed without reset");
    // Flag set, hold and clear
    chk_cflag_set: assert property (@(posedge mclk) disable iff (rst)
        corr_detect |=> flags.correctable_error_flag)
        else $error("correctable flag not set");
    chk_uflag_hold: assert property (@(posedge mclk) disable iff (rst)
        (flags.uncorrectable_error_flag && !flag_clr_we) |=> flags.uncorrectable_error_flag)
        else $error("uncorrectable flag lost without clear");
    chk_uflag_clear: assert property (@(posedge mclk) disable iff (rst)
        (flag_clr_we && flag_clr_mask.uncorrectable_error_flag && !uncorr_detect)
        |=> !flags.uncorrectable_error_flag)
        else $error("uncorrectable flag not cleared");
    chk_cflag_clear: assert property (@(posedge mclk) disable iff (rst)
        (flag_clr_we && flag_clr_mask.correctable_error_flag && !corr_detect)
        |=> !flags.correctable_error_flag)
        else $error("correctable flag not cleared");
    chk_spurious_no_flag: assert property (@(posedge mclk) disable iff (rst)
        (spurious_detect && !uncorr_detect && !flags.uncorrectable_error_flag)
        |=> !flags.uncorrectable_error_flag)
        else $error("spurious detection set the flag");
    // NMI and control register
    chk_nmi_hold: assert property (@(posedge mclk) disable iff (rst)
        (nmi_req && !nmi_ack) |=> nmi_req)
        else $error("NMI request dropped before ack");
    chk_nmi_ack: assert property (@(posedge mclk) disable iff (rst)
        (nmi_ack && !uncorr_nmi && !corr_nmi) |=> !nmi_req && system_nmi_vector == NMI_NONE)
        else $error("NMI not cleared by ack");
    chk_ctl_write: assert property (@(posedge mclk) disable iff (rst)
        ctl_we |=> ctl == $past(ctl_wdata))
        else $error("control write lost");
    chk_power_on: assert property (@(posedge mclk) disable iff (rst)
        (ctl_we && ctl_wdata.memory_power_enable) |=> memory_power_enable)
        else $error("memory power not switched on");
endmodule : fbe_report

// >>> fbe_report_tb.sv
// Randomised self-checking bench for the memory bit error reporting block
`timescale 1ns/1ps
module fbe_report_tb;
import fbe_pkg::*;
logic mclk = 1'h0, rst = 1'h1, ctl_we = 1'h0, flag_clr_we = 1'h0, nmi_ack = 1'h0;
logic uncorr_detect = 1'h0, corr_detect = 1'h0, spurious_detect = 1'h0;
fbe_ctl_a_t ctl_wdata = 4'h0, ctl, c;
fbe_flags_t flag_clr_mask = 2'h0, flags;
logic [7:0] reset_cause_vector, system_nmi_vector, rv = 8'h00;
logic nmi_req, power_up_clear_reset, memory_power_enable;
logic [31:0] seed = 32'h161d3, r;
int miscompares = 0, samples_checked = 0, k;
fbe_report dut_u (.mclk, .rst, .ctl_we, .ctl_wdata, .flag_clr_we, .flag_clr_mask,
    .uncorr_detect, .corr_detect, .spurious_detect, .nmi_ack, .ctl, .flags,
    .reset_cause_vector, .system_nmi_vector, .nmi_req, .power_up_clear_reset,
    .memory_power_enable);
////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction : xs
// Vector expected after an ack, so only the new cause can show
function automatic logic [7:0] exp_nmi(int kind, fbe_ctl_a_t cc);
    if (kind == 0 && cc.uncorrectable_irq_enable) return NMI_UNCORR;
    if (kind == 1 && cc.correctable_irq_enable) return NMI_CORR;
    return NMI_NONE;
endfunction : exp_nmi
task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
        miscompares++;
        $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
endtask : chk
task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask : test_done
////////////////////////////////////////////////////////////////////////////////
initial forever #2.5 mclk = ~mclk;
initial begin
    #20000;
    miscompares++;
    test_done();
end
initial begin
    repeat (12) @(negedge mclk);
    rst = 1'h0;
    chk("ctl", ctl, {{3{CTL_EN_RESET}}, PWR_EN_RESET});
    chk("flags", flags, 2'h0);
    chk("rst_vec", reset_cause_vector, RST_NONE);
    chk("nmi_vec", system_nmi_vector, NMI_NONE);
    for (int i = 0; i < 40; i++) begin
        r = xs();
        c = r[3:0];
        k = xs() % 3;
        ctl_wdata = c;
        ctl_we = 1'h1;
        flag_clr_we = 1'h1;
        flag_clr_mask = 2'h3;
        nmi_ack = 1'h1;
        @(negedge mclk);
        {ctl_we, flag_clr_we, nmi_ack} = 3'h0;
        {uncorr_detect, corr_detect, spurious_detect} = {k == 0, k == 1, k == 2};
        @(negedge mclk);
        {uncorr_detect, corr_detect, spurious_detect} = 3'h0;
        // Spurious hits still reset, but leave no cause behind
        if (c.uncorrectable_reset_enable && k != 1) rv = (k == 0) ? RST_UNCORR : RST_NONE;
        chk("ctl", ctl, c);
        chk("power", memory_power_enable, c.memory_power_enable);
        chk("flags", flags, {k == 0, k == 1});
        chk("puc", power_up_clear_reset, c.uncorrectable_reset_enable && k != 1);
        chk("rst_vec", reset_cause_vector, rv);
        chk("nmi_vec", system_nmi_vector, exp_nmi(k, c));
        chk("nmi_req", nmi_req, exp_nmi(k, c) != NMI_NONE);
        repeat (4) @(negedge mclk);
        chk("puc_end", power_up_clear_reset, 1'h0);
        chk("flags_hold", flags, {k == 0, k == 1});
        chk("nmi_hold", nmi_req, exp_nmi(k, c) != NMI_NONE);
        $display("test %0d done", i);
    end
    // Poll after a reset, clear racing a set, detection during the pulse
    ctl_wdata = 4'h9;
    {ctl_we, flag_clr_we, nmi_ack} = 3'h7;
    flag_clr_mask = 2'h3;
    @(negedge mclk);
    {ctl_we, nmi_ack} = 2'h0;
    uncorr_detect = 1'h1;
    @(negedge mclk);
    flag_clr_we = 1'h0;
    chk("set_wins", flags, 2'h2);
    chk("puc_on", power_up_clear_reset, 1'h1);
    @(negedge mclk);
    uncorr_detect = 1'h0;
    repeat (3) @(negedge mclk);
    chk("poll_flag", flags, 2'h2);
    chk("poll_cause", reset_cause_vector, RST_UNCORR);
    chk("poll_nmi", nmi_req, 1'h0);
    chk("puc_once", power_up_clear_reset, 1'h0);
    $display("test poll done");
    // Low-power entry with everything off, then false errors on wake-up
    ctl_wdata = 4'h0;
    ctl_we = 1'h1;
    @(negedge mclk);
    ctl_we = 1'h0;
    {corr_detect, spurious_detect} = 2'h3;
    @(negedge mclk);
    {corr_detect, spurious_detect} = 2'h0;
    chk("lp_power", memory_power_enable, 1'h0);
    chk("lp_puc", power_up_clear_reset, 1'h0);
    chk("lp_nmi", nmi_req, 1'h0);
    flag_clr_we = 1'h1;
    @(negedge mclk);
    flag_clr_we = 1'h0;
    ctl_wdata = 4'h7;
    ctl_we = 1'h1;
    chk("wake_flags", flags, 2'h0);
    @(negedge mclk);
    ctl_we = 1'h0;
    {uncorr_detect, corr_detect} = 2'h3;
    chk("wake_ctl", ctl, 4'h7);
    @(negedge mclk);
    {uncorr_detect, corr_detect} = 2'h0;
    chk("both_vec", system_nmi_vector, NMI_UNCORR);
    chk("both_flags", flags, 2'h3);
    $display("test low power done");
    uncorr_detect = 1'h1;
    @(negedge mclk);
    uncorr_detect = 1'h0;
    rst = 1'h1;
    @(negedge mclk);
    rst = 1'h0;
    chk("flags_bor", flags, 2'h0);
    chk("ctl_bor", ctl, {{3{CTL_EN_RESET}}, PWR_EN_RESET});
    chk("nmi_bor", nmi_req, 1'h0);
    test_done();
end
endmodule : fbe_report_tb
